// File: core/fflmb_top.sv
// Flag and mailbox logic for a dual queue, three port buffer.
// Assumes the data path reports each word moved from memory to an output register.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Full flag low blocks writes
// - Same flag: input ready or full by mode
// - Write pointer steps; full flag on writer clock
// - Full flag rises on second writer edge
// - Edge too near read not counted
// - Almost-empty high above offset, low otherwise
// - Port B uses fifo1, port A fifo2
// - Almost-empty rises on second reader edge
// - Edge too near write not counted
// - Almost-full low at depth minus offset
// - Almost-full offsets per queue, writer clock
// - Almost-full rises on second writer edge
// - Output register word not counted
// - Offsets preset, parallel or serial loaded
// - Two 18-bit bypass mail registers
// - Port A writes A-to-B mail
// - Port C writes C-to-A mail
// - Mail write clears flag, blocks further writes
// - Mailbox select picks mail or queue data
// - Port B mail read sets flag
// - Port A mail read sets flag
// - Reading mail keeps contents
// - Full, almost-empty and almost-full flags pass two stages on port clock
// - Mail data ignores byte order
module fflmb_top (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	// Port clocks and straps
	input  wire logic        i_port_a_clock,
	input  wire logic        i_port_b_clock,
	input  wire logic        i_port_c_clock,
	input  wire logic        i_first_word_fall_through_mode,
	input  wire logic [1:0]  i_offset_preset_sel,
	// Port A
	input  wire logic        i_port_a_chip_select_n,
	input  wire logic        i_port_a_write_not_read,
	input  wire logic        i_port_a_enable,
	input  wire logic        i_port_a_mailbox_select,
	input  wire logic        i_port_a_offset_program,
	input  wire logic        i_port_a_serial_enable,
	input  wire logic        i_port_a_serial_data,
	input  wire logic [35:0] i_port_a_data,
	output logic      [35:0] o_port_a_data,
	output logic             o_port_a_data_oe_n,
	// Port B
	input  wire logic        i_port_b_chip_select_n,
	input  wire logic        i_port_b_read_enable,
	input  wire logic        i_port_b_mailbox_select,
	input  wire logic        i_port_b_size_byte,
	output logic      [17:0] o_port_b_data,
	output logic             o_port_b_data_oe_n,
	// Port C
	input  wire logic        i_port_c_write_enable,
	input  wire logic        i_port_c_mailbox_select,
	input  wire logic        i_port_c_size_byte,
	input  wire logic [17:0] i_port_c_data,
	// Data path
	input  wire logic        i_fifo1_mem_read,
	input  wire logic        i_fifo2_mem_read,
	input  wire logic [17:0] i_fifo1_out_data,
	input  wire logic [35:0] i_fifo2_out_data,
	output logic             o_fifo1_write,
	output logic             o_fifo2_write,
	output logic             o_first_word_fall_through_mode,
	// Flags
	output logic             o_port_a_full_or_input_ready,
	output logic             o_port_c_full_or_input_ready,
	output logic             o_port_a_almost_empty_flag,
	output logic             o_port_b_almost_empty_flag,
	output logic             o_port_a_almost_full_flag,
	output logic             o_port_c_almost_full_flag,
	output logic             o_a_to_b_mail_flag,
	output logic             o_c_to_a_mail_flag
);
	fflmb_pkg::fflmb_state_t            r_reg;
	fflmb_pkg::fflmb_state_t            r_next;
	fflmb_pkg::fflmb_pins_t             raw_pins;
	fflmb_pkg::fflmb_pins_t             pin;
	logic                               a_edge;
	logic                               b_edge;
	logic                               c_edge;
	logic                               a_sel_wr;
	logic                               a_sel_rd;
	logic                               b_sel_rd;
	logic                               c_sel_wr;
	logic                               f1_wr;
	logic                               f2_wr;
	logic                               f1_rd;
	logic                               f2_rd;
	logic                               m1_wr;
	logic                               m2_wr;
	logic                               ofs_par;
	logic                               ofs_ser;
	logic [fflmb_pkg::CNT_W-1:0]        cnt1;
	logic [fflmb_pkg::CNT_W-1:0]        cnt2;
	logic [fflmb_pkg::CNT_W-1:0]        cnt1_w;
	logic [fflmb_pkg::CNT_W-1:0]        cnt2_w;
	logic [fflmb_pkg::CNT_W-1:0]        cnt1_r;
	logic [fflmb_pkg::CNT_W-1:0]        cnt2_r;
	logic [fflmb_pkg::OFS_W-1:0]        x1;
	logic [fflmb_pkg::OFS_W-1:0]        y1;
	logic [fflmb_pkg::OFS_W-1:0]        x2;
	logic [fflmb_pkg::OFS_W-1:0]        y2;
	logic [fflmb_pkg::MAIL_W-1:0]       m1_data;
	logic [fflmb_pkg::MAIL_W-1:0]       m2_data;
	logic [fflmb_pkg::N_FLAGS-1:0]      flag_edge;
	logic [fflmb_pkg::N_FLAGS-1:0]      flag_raw;
	logic [fflmb_pkg::N_FLAGS-1:0]      flag;

	function automatic logic [fflmb_pkg::MAIL_W-1:0] lane_mask(input logic byte_size);
		lane_mask = byte_size ? fflmb_pkg::BYTE_MASK : fflmb_pkg::WORD_MASK;
	endfunction : lane_mask

	function automatic logic [fflmb_pkg::OFS_W-1:0] preset_value(input logic [1:0] sel);
		if (sel == fflmb_pkg::PRESET_SEL_8) begin
			preset_value = fflmb_pkg::PRESET_8;
		end else if (sel == fflmb_pkg::PRESET_SEL_16) begin
			preset_value = fflmb_pkg::PRESET_16;
		end else begin
			preset_value = fflmb_pkg::PRESET_64;
		end
	endfunction : preset_value

	function automatic logic af_clear(input logic [fflmb_pkg::CNT_W-1:0] cnt,
		input logic [fflmb_pkg::OFS_W-1:0] ofs);
		af_clear = ({1'b0, cnt} + {2'b00, ofs}) < {1'b0, fflmb_pkg::DEPTH_CNT};
	endfunction : af_clear

	always_comb begin
		raw_pins          = '0;
		raw_pins.a_clk    = i_port_a_clock;
		raw_pins.b_clk    = i_port_b_clock;
		raw_pins.c_clk    = i_port_c_clock;
		raw_pins.first_word_fall_through_mode     = i_first_word_fall_through_mode;
		raw_pins.ofs_sel  = i_offset_preset_sel;
		raw_pins.a_cs_n   = i_port_a_chip_select_n;
		raw_pins.a_wnr    = i_port_a_write_not_read;
		raw_pins.a_en     = i_port_a_enable;
		raw_pins.a_mb     = i_port_a_mailbox_select;
		raw_pins.a_prog   = i_port_a_offset_program;
		raw_pins.a_ser_en = i_port_a_serial_enable;
		raw_pins.a_ser_d  = i_port_a_serial_data;
		raw_pins.a_data   = i_port_a_data;
		raw_pins.b_cs_n   = i_port_b_chip_select_n;
		raw_pins.b_ren    = i_port_b_read_enable;
		raw_pins.b_mb     = i_port_b_mailbox_select;
		raw_pins.b_byte   = i_port_b_size_byte;
		raw_pins.c_wen    = i_port_c_write_enable;
		raw_pins.c_mb     = i_port_c_mailbox_select;
		raw_pins.c_byte   = i_port_c_size_byte;
		raw_pins.c_data   = i_port_c_data;
	end

	// Clocks and controls share one synchroniser so they stay aligned
	fflmb_sync u_sync (
		.i_sys_clk (i_sys_clk),
		.i_pins    (raw_pins),
		.o_pins    (pin)
	);

	// Port clock edges and selected operations
	assign a_edge   = pin.a_clk & ~r_reg.clk_prev[0];
	assign b_edge   = pin.b_clk & ~r_reg.clk_prev[1];
	assign c_edge   = pin.c_clk & ~r_reg.clk_prev[2];
	assign a_sel_wr = a_edge & ~pin.a_cs_n & pin.a_wnr & pin.a_en;
	assign a_sel_rd = a_edge & ~pin.a_cs_n & ~pin.a_wnr & pin.a_en;
	assign b_sel_rd = b_edge & ~pin.b_cs_n & pin.b_ren;
	assign c_sel_wr = c_edge & pin.c_wen;

	// Queue writes only while a location is free
	assign f1_wr    = a_sel_wr & ~pin.a_mb & ~pin.a_prog & flag[fflmb_pkg::F_FULL_A];
	assign f2_wr    = c_sel_wr & ~pin.c_mb & flag[fflmb_pkg::F_FULL_C];
	// Output register word has left memory, so only memory words count
	assign f1_rd    = i_fifo1_mem_read & (cnt1 != '0);
	assign f2_rd    = i_fifo2_mem_read & (cnt2 != '0);
	assign ofs_par  = a_sel_wr & pin.a_prog;
	assign ofs_ser  = a_edge & pin.a_ser_en;

	// Mail writes only while the flag shows the box empty
	assign m1_wr    = a_sel_wr & pin.a_mb & ~pin.a_prog & r_reg.a_to_b_mail_flag;
	assign m2_wr    = c_sel_wr & pin.c_mb & r_reg.c_to_a_mail_flag;
	// Lanes pass straight through, no byte reordering
	assign m1_data  = pin.a_data[fflmb_pkg::MAIL_W-1:0] & lane_mask(pin.b_byte);
	assign m2_data  = pin.c_data & lane_mask(pin.c_byte);

	assign x1       = r_reg.ofs[fflmb_pkg::X1_LSB +: fflmb_pkg::OFS_W];
	assign y1       = r_reg.ofs[fflmb_pkg::Y1_LSB +: fflmb_pkg::OFS_W];
	assign x2       = r_reg.ofs[fflmb_pkg::X2_LSB +: fflmb_pkg::OFS_W];
	assign y2       = r_reg.ofs[fflmb_pkg::Y2_LSB +: fflmb_pkg::OFS_W];

	// Memory fill levels
	assign cnt1     = r_reg.wptr1 - r_reg.rptr1;
	assign cnt2     = r_reg.wptr2 - r_reg.rptr2;
	// Each side sees only its own event this cycle; the other side's
	// event is seen one cycle later, so a coincident edge never counts
	assign cnt1_w   = cnt1 + {{(fflmb_pkg::CNT_W-1){1'b0}}, f1_wr};
	assign cnt2_w   = cnt2 + {{(fflmb_pkg::CNT_W-1){1'b0}}, f2_wr};
	assign cnt1_r   = cnt1 - {{(fflmb_pkg::CNT_W-1){1'b0}}, f1_rd};
	assign cnt2_r   = cnt2 - {{(fflmb_pkg::CNT_W-1){1'b0}}, f2_rd};

	// Three flags per queue, each on the clock of the port it serves
	assign flag_edge = {c_edge, a_edge, a_edge, b_edge, c_edge, a_edge};
	assign flag_raw[fflmb_pkg::F_FULL_A] = cnt1_w < fflmb_pkg::DEPTH_CNT;
	assign flag_raw[fflmb_pkg::F_FULL_C] = cnt2_w < fflmb_pkg::DEPTH_CNT;
	assign flag_raw[fflmb_pkg::F_AE_B]   = cnt1_r > {1'b0, x1};
	assign flag_raw[fflmb_pkg::F_AE_A]   = cnt2_r > {1'b0, x2};
	assign flag_raw[fflmb_pkg::F_AF_A]   = af_clear(cnt1_w, y1);
	assign flag_raw[fflmb_pkg::F_AF_C]   = af_clear(cnt2_w, y2);

	// Two stages per flag: high only after two port edges
	for (genvar g = 0; g < fflmb_pkg::N_FLAGS; g++) begin : g_flag
		fflmb_flag u_flag (
			.i_sys_clk (i_sys_clk),
			.i_resetn  (i_resetn),
			.i_edge    (flag_edge[g]),
			.i_raw     (flag_raw[g]),
			.o_flag    (flag[g])
		);
	end

	always_comb begin
		r_next          = r_reg;
		r_next.clk_prev = {pin.c_clk, pin.b_clk, pin.a_clk};
		if (f1_wr) begin
			r_next.wptr1 = r_reg.wptr1 + 11'h001;
		end
		if (f2_wr) begin
			r_next.wptr2 = r_reg.wptr2 + 11'h001;
		end
		if (f1_rd) begin
			r_next.rptr1 = r_reg.rptr1 + 11'h001;
		end
		if (f2_rd) begin
			r_next.rptr2 = r_reg.rptr2 + 11'h001;
		end
		// Parallel and serial loading both shift the same offset chain
		if (ofs_par) begin
			r_next.ofs = {r_reg.ofs[fflmb_pkg::OFS_VEC_W-fflmb_pkg::OFS_W-1:0],
				pin.a_data[fflmb_pkg::OFS_W-1:0]};
		end else if (ofs_ser) begin
			r_next.ofs = {r_reg.ofs[fflmb_pkg::OFS_VEC_W-2:0], pin.a_ser_d};
		end
		// Contents change only on an accepted write or reset
		if (m1_wr) begin
			r_next.a_to_b_mail_register = m1_data;
		end
		if (m2_wr) begin
			r_next.c_to_a_mail_register = m2_data;
		end
		// New mail wins over a read on the same cycle
		if (m1_wr) begin
			r_next.a_to_b_mail_flag = 1'b0;
		end else if (b_sel_rd && pin.b_mb) begin
			r_next.a_to_b_mail_flag = 1'b1;
		end
		if (m2_wr) begin
			r_next.c_to_a_mail_flag = 1'b0;
		end else if (a_sel_rd && pin.a_mb) begin
			r_next.c_to_a_mail_flag = 1'b1;
		end
		// Mail on upper lanes of port A; lower lanes undefined, driven zero
		r_next.a_out  = pin.a_mb ? {r_reg.c_to_a_mail_register, fflmb_pkg::MAIL_RESET} : i_fifo2_out_data;
		r_next.b_out  = pin.b_mb ? r_reg.a_to_b_mail_register : i_fifo1_out_data;
		r_next.a_oe_n = pin.a_cs_n | pin.a_wnr;
		r_next.b_oe_n = pin.b_cs_n;
		r_next.wr1    = f1_wr;
		r_next.wr2    = f2_wr;
		if (!i_resetn) begin
			r_next        = '0;
			r_next.a_to_b_mail_flag   = fflmb_pkg::MBF_RESET;
			r_next.c_to_a_mail_flag   = fflmb_pkg::MBF_RESET;
			r_next.a_oe_n = 1'b1;
			r_next.b_oe_n = 1'b1;
			r_next.ofs    = {4{preset_value(pin.ofs_sel)}};
			// Track clock levels in reset so a clock high at release is no edge
			r_next.clk_prev = {pin.c_clk, pin.b_clk, pin.a_clk};
			// Timing mode caught every reset cycle, frozen at release
			r_next.first_word_fall_through_mode   = pin.first_word_fall_through_mode;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		r_reg <= r_next;
	end

	// Both timing modes share one flag; only its name differs
	assign o_port_a_full_or_input_ready   = flag[fflmb_pkg::F_FULL_A];
	assign o_port_c_full_or_input_ready   = flag[fflmb_pkg::F_FULL_C];
	assign o_port_b_almost_empty_flag     = flag[fflmb_pkg::F_AE_B];
	assign o_port_a_almost_empty_flag     = flag[fflmb_pkg::F_AE_A];
	assign o_port_a_almost_full_flag      = flag[fflmb_pkg::F_AF_A];
	assign o_port_c_almost_full_flag      = flag[fflmb_pkg::F_AF_C];
	assign o_a_to_b_mail_flag             = r_reg.a_to_b_mail_flag;
	assign o_c_to_a_mail_flag             = r_reg.c_to_a_mail_flag;
	assign o_port_a_data                  = r_reg.a_out;
	assign o_port_a_data_oe_n             = r_reg.a_oe_n;
	assign o_port_b_data                  = r_reg.b_out;
	assign o_port_b_data_oe_n             = r_reg.b_oe_n;
	assign o_fifo1_write                  = r_reg.wr1;
	assign o_fifo2_write                  = r_reg.wr2;
	assign o_first_word_fall_through_mode = r_reg.first_word_fall_through_mode;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_a_to_b_mail_register_write;
		m1_wr;
	endsequence

	sequence s_a_to_b_mail_register_read;
		b_sel_rd && pin.b_mb && !m1_wr;
	endsequence

	a_full_blocks_write: assert property (
		!flag[fflmb_pkg::F_FULL_A] && a_sel_wr |=> $stable(r_reg.wptr1))
		else $error("queue write taken while full");

	a_full_flag_sound: assert property (
		o_port_a_full_or_input_ready |-> cnt1 < fflmb_pkg::DEPTH_CNT)
		else $error("full flag high with no free location");

	a_wptr_step: assert property (
		f1_wr |=> r_reg.wptr1 == 11'($past(r_reg.wptr1) + 11'h001) && o_fifo1_write)
		else $error("write pointer did not step");

	a_ae_on_edge: assert property (
		$rose(o_port_b_almost_empty_flag) |-> $past(b_edge) && cnt1 > {1'b0, x1})
		else $error("almost-empty rose off its port edge");

	a_af_low_limit: assert property (
		o_port_c_almost_full_flag |-> af_clear(cnt2, y2))
		else $error("almost-full high at or past its limit");

	a_mail_write_clears: assert property (
		s_a_to_b_mail_register_write |=> !o_a_to_b_mail_flag && r_reg.a_to_b_mail_register == $past(m1_data))
		else $error("mail write did not store or clear flag");

	a_mail_write_ignored: assert property (
		a_sel_wr && pin.a_mb && !r_reg.a_to_b_mail_flag |=> $stable(r_reg.a_to_b_mail_register) ##1 $stable(r_reg.a_to_b_mail_register))
		else $error("mail overwritten while flag low");

	a_mail_read_sets: assert property (
		s_a_to_b_mail_register_read |=> o_a_to_b_mail_flag ##1 o_port_b_data == $past(r_reg.a_to_b_mail_register))
		else $error("mail read did not set flag or show data");

	a_mail_read_keeps: assert property (
		a_sel_rd && pin.a_mb && !m2_wr |=> $stable(r_reg.c_to_a_mail_register) && o_c_to_a_mail_flag)
		else $error("mail read altered contents or flag");
endmodule : fflmb_top
`default_nettype wire

// File: core/fflmb_pkg.sv
// Constants and types for the FIFO flag and mailbox block.
// Assumes one system clock; all port pins are sampled through synchronisers.
package fflmb_pkg;

	// Memory depth and counter widths
	localparam int                 CNT_W        = 11;
	localparam int                 OFS_W        = 10;
	localparam int                 MAIL_W       = 18;
	localparam int                 A_W          = 36;
	localparam logic [CNT_W-1:0]   DEPTH_CNT    = 11'h400;

	// Offset presets chosen by strap during reset
	localparam logic [1:0]         PRESET_SEL_8  = 2'h0;
	localparam logic [1:0]         PRESET_SEL_16 = 2'h1;
	localparam logic [OFS_W-1:0]   PRESET_8     = 10'h008;
	localparam logic [OFS_W-1:0]   PRESET_16    = 10'h010;
	localparam logic [OFS_W-1:0]   PRESET_64    = 10'h040;

	// Offset vector: fifo1 empty, fifo1 full, fifo2 empty, fifo2 full
	localparam int                 OFS_VEC_W    = 40;
	localparam int                 X1_LSB       = 30;
	localparam int                 Y1_LSB       = 20;
	localparam int                 X2_LSB       = 10;
	localparam int                 Y2_LSB       = 0;

	// Mail lanes and reset values
	localparam logic [MAIL_W-1:0]  BYTE_MASK    = 18'h001ff;
	localparam logic [MAIL_W-1:0]  WORD_MASK    = 18'h3ffff;
	localparam logic [MAIL_W-1:0]  MAIL_RESET   = 18'h00000;
	localparam logic               MBF_RESET    = 1'b1;

	// Flag indices
	localparam int                 N_FLAGS      = 6;
	localparam int                 F_FULL_A     = 0;
	localparam int                 F_FULL_C     = 1;
	localparam int                 F_AE_B       = 2;
	localparam int                 F_AE_A       = 3;
	localparam int                 F_AF_A       = 4;
	localparam int                 F_AF_C       = 5;

	typedef struct packed {
		logic              a_clk;
		logic              b_clk;
		logic              c_clk;
		logic              first_word_fall_through_mode;
		logic [1:0]        ofs_sel;
		logic              a_cs_n;
		logic              a_wnr;
		logic              a_en;
		logic              a_mb;
		logic              a_prog;
		logic              a_ser_en;
		logic              a_ser_d;
		logic [A_W-1:0]    a_data;
		logic              b_cs_n;
		logic              b_ren;
		logic              b_mb;
		logic              b_byte;
		logic              c_wen;
		logic              c_mb;
		logic              c_byte;
		logic [MAIL_W-1:0] c_data;
	} fflmb_pins_t;

	typedef struct packed {
		fflmb_pins_t s1;
		fflmb_pins_t s2;
		fflmb_pins_t s3;
		fflmb_pins_t lvl;
	} fflmb_sync_t;

	typedef struct packed {
		logic s1;
		logic flag;
	} fflmb_flag_t;

	typedef struct packed {
		logic [2:0]           clk_prev;
		logic [CNT_W-1:0]     wptr1;
		logic [CNT_W-1:0]     rptr1;
		logic [CNT_W-1:0]     wptr2;
		logic [CNT_W-1:0]     rptr2;
		logic [OFS_VEC_W-1:0] ofs;
		logic [MAIL_W-1:0]    a_to_b_mail_register;
		logic [MAIL_W-1:0]    c_to_a_mail_register;
		logic                 a_to_b_mail_flag;
		logic                 c_to_a_mail_flag;
		logic                 first_word_fall_through_mode;
		logic [A_W-1:0]       a_out;
		logic                 a_oe_n;
		logic [MAIL_W-1:0]    b_out;
		logic                 b_oe_n;
		logic                 wr1;
		logic                 wr2;
	} fflmb_state_t;

endpackage : fflmb_pkg

// File: core/fflmb_sync.sv
// Three-stage synchroniser for every port pin.
// Assumes pins are quasi-static around their own port clock edges.
`timescale 1ns/1ps
`default_nettype none
module fflmb_sync (
	// Clock
	input  wire logic                   i_sys_clk,
	// Raw pins and filtered levels
	input  wire fflmb_pkg::fflmb_pins_t i_pins,
	output var fflmb_pkg::fflmb_pins_t  o_pins
);
	fflmb_pkg::fflmb_sync_t r_reg;
	fflmb_pkg::fflmb_sync_t r_next;

	// No reset: straps must pass through while reset is held
	always_comb begin
		r_next     = r_reg;
		r_next.s1  = i_pins;
		r_next.s2  = r_reg.s1;
		r_next.s3  = r_reg.s2;
		// A level changes only once stages two and three agree
		r_next.lvl = (r_reg.s2 & r_reg.s3) | (r_reg.lvl & (r_reg.s2 | r_reg.s3));
	end

	always_ff @(posedge i_sys_clk) begin
		r_reg <= r_next;
	end

	assign o_pins = r_reg.lvl;
endmodule : fflmb_sync
`default_nettype wire

// File: core/fflmb_flag.sv
// One status flag retimed to its own port clock edge.
// Assumes i_raw already includes the event of this same edge.
`timescale 1ns/1ps
`default_nettype none
module fflmb_flag (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	// Port clock edge and raw condition
	input  wire logic i_edge,
	input  wire logic i_raw,
	// Retimed flag
	output logic      o_flag
);
	fflmb_pkg::fflmb_flag_t r_reg;
	fflmb_pkg::fflmb_flag_t r_next;

	// Falling takes one port edge, rising takes two port edges
	always_comb begin
		r_next = r_reg;
		if (!i_resetn) begin
			r_next = '0;
		end else if (i_edge) begin
			r_next.s1   = i_raw;
			r_next.flag = r_reg.s1 & i_raw;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		r_reg <= r_next;
	end

	assign o_flag = r_reg.flag;
endmodule : fflmb_flag
`default_nettype wire

// File: testbench/fflmb_port_clk.sv
// Port side clock source, one free running port clock per instance.
// Assumes the bench places the port controls around these edges.
`timescale 1ns/1ps
`default_nettype none
module fflmb_port_clk #(
	parameter real HALF_NS = 200.0
) (
	// Port clock
	output logic o_clk
);
	// Free running, so flags keep settling between transfers
	initial begin
		o_clk = 1'b0;
		forever #(HALF_NS) o_clk = ~o_clk;
	end
endmodule : fflmb_port_clk
`default_nettype wire

// File: testbench/fflmb_top_tb.sv
// Bench for the flag and mailbox block: mail both ways, fill, refuse, drain.
// Assumes port clocks ten to sixteen system cycles long, each unrelated to the others.
`timescale 1ns/1ps
`default_nettype none
module fflmb_top_tb;
	localparam logic [17:0] FO1 = 18'h2aa55;
	logic        i_sys_clk;
	logic        i_resetn = 1'b0, a_cs_n = 1'b1, a_wnr = 1'b0, a_en = 1'b0, a_mb = 1'b0;
	logic        b_cs_n = 1'b1, b_ren = 1'b0, b_mb = 1'b0, c_wen = 1'b0, c_mb = 1'b0;
	logic        c_byte = 1'b0, mem1 = 1'b0, tie0 = 1'b0, first_word_fall_through_mode = 1'b1, a_prog = 1'b0;
	logic [35:0] a_d = 36'h0, a_q;
	logic [17:0] c_d = 18'h0, b_q;
	logic        a_oe_n, b_oe_n, w1, w2, first_word_fall_through_mode_q, ff_a, ff_c, ae_a, ae_b, af_a, af_c, mf1, mf2;
	wire         a_clk, b_clk, c_clk;
	int          num_errors = 0, n_tests = 0, wr1 = 0, wr2 = 0, nbe = 0, nb_wr = 0;

	fflmb_port_clk #(.HALF_NS(200.0)) fflmb_port_clk_a_i (.o_clk(a_clk));
	// Half periods of multiples of 40 ns put every port edge on a system falling edge,
	// and 200, 240 and 320 never let two port rising edges meet
	fflmb_port_clk #(.HALF_NS(320.0)) fflmb_port_clk_b_i (.o_clk(b_clk));
	fflmb_port_clk #(.HALF_NS(240.0)) fflmb_port_clk_c_i (.o_clk(c_clk));

	fflmb_top fflmb_top_i (
		.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_port_a_clock(a_clk), .i_port_b_clock(b_clk), .i_port_c_clock(c_clk),
		.i_first_word_fall_through_mode(first_word_fall_through_mode), .i_offset_preset_sel(fflmb_pkg::PRESET_SEL_8),
		.i_port_a_chip_select_n(a_cs_n), .i_port_a_write_not_read(a_wnr),
		.i_port_a_enable(a_en), .i_port_a_mailbox_select(a_mb),
		.i_port_a_offset_program(a_prog), .i_port_a_serial_enable(tie0),
		.i_port_a_serial_data(tie0), .i_port_a_data(a_d),
		.o_port_a_data(a_q), .o_port_a_data_oe_n(a_oe_n),
		.i_port_b_chip_select_n(b_cs_n), .i_port_b_read_enable(b_ren),
		.i_port_b_mailbox_select(b_mb), .i_port_b_size_byte(tie0),
		.o_port_b_data(b_q), .o_port_b_data_oe_n(b_oe_n),
		.i_port_c_write_enable(c_wen), .i_port_c_mailbox_select(c_mb),
		.i_port_c_size_byte(c_byte), .i_port_c_data(c_d),
		.i_fifo1_mem_read(mem1), .i_fifo2_mem_read(tie0),
		.i_fifo1_out_data(FO1), .i_fifo2_out_data({FO1, FO1}),
		.o_fifo1_write(w1), .o_fifo2_write(w2), .o_first_word_fall_through_mode(first_word_fall_through_mode_q),
		.o_port_a_full_or_input_ready(ff_a), .o_port_c_full_or_input_ready(ff_c),
		.o_port_a_almost_empty_flag(ae_a), .o_port_b_almost_empty_flag(ae_b),
		.o_port_a_almost_full_flag(af_a), .o_port_c_almost_full_flag(af_c),
		.o_a_to_b_mail_flag(mf1), .o_c_to_a_mail_flag(mf2)
	);

	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	always @(posedge i_sys_clk) begin
		if (w1 === 1'b1) wr1++;
		if (w2 === 1'b1) wr2++;
	end

	always @(posedge b_clk) nbe++;

	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic end_test(input string nm);
		$display("test %s done, checks so far %0d", nm, n_tests);
	endtask : end_test

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict

	// Controls settle well before a port edge and hold past the synchroniser delay
	task automatic edges(input int p, input int n);
		repeat (n) case (p)
			0: @(posedge a_clk);
			1: @(posedge b_clk);
			default: @(posedge c_clk);
		endcase
		if (p == 0) nb_wr = nbe;
		repeat (6) @(posedge i_sys_clk);
		#1;
	endtask : edges

	task automatic op_a(input logic wnr, input logic mb, input logic [35:0] d);
		@(negedge a_clk);
		@(posedge i_sys_clk);
		#1;
		a_cs_n = 1'b0;
		a_wnr  = wnr;
		a_en   = 1'b1;
		a_mb   = mb;
		a_d    = d;
		edges(0, 1);
		a_cs_n = 1'b1;
		a_en   = 1'b0;
	endtask : op_a

	task automatic op_b(input logic mb);
		@(negedge b_clk);
		@(posedge i_sys_clk);
		#1;
		b_cs_n = 1'b0;
		b_ren  = 1'b1;
		b_mb   = mb;
		edges(1, 1);
		b_cs_n = 1'b1;
		b_ren  = 1'b0;
	endtask : op_b

	task automatic op_c(input logic mb, input logic [17:0] d);
		@(negedge c_clk);
		@(posedge i_sys_clk);
		#1;
		c_wen = 1'b1;
		c_mb  = mb;
		c_d   = d;
		edges(2, 1);
		c_wen = 1'b0;
	endtask : op_c

	initial begin
		#2ms;
		num_errors++;
		$display("[FAIL] run length expected finish seen hang");
		give_verdict();
	end

	initial begin
		// Five edges: straps need four to clear the synchroniser and one to be caught
		repeat (5) @(posedge i_sys_clk);
		#1;
		chk("ff_a in reset", 36'h0, ff_a);
		chk("mf1 in reset", 36'h1, mf1);
		chk("a_oe_n in reset", 36'h1, a_oe_n);
		i_resetn = 1'b1;
		edges(0, 2);
		edges(2, 2);
		chk("first_word_fall_through_mode latched", 36'h1, first_word_fall_through_mode_q);
		chk("ff_a ready", 36'h1, ff_a);
		chk("ff_c ready", 36'h1, ff_c);
		chk("af_c idle", 36'h1, af_c);
		chk("ae_a empty", 36'h0, ae_a);
		end_test("reset");
		op_a(1'b1, 1'b1, 36'hf_fff2_1234);
		chk("mf1 after write", 36'h0, mf1);
		op_a(1'b1, 1'b1, 36'h0_0001_5555);
		op_b(1'b1);
		chk("mf1 after read", 36'h1, mf1);
		chk("a_to_b_mail_register data", 36'h21234, b_q);
		chk("b_oe_n driving", 36'h0, b_oe_n);
		op_b(1'b1);
		chk("a_to_b_mail_register kept", 36'h21234, b_q);
		op_b(1'b0);
		chk("b queue data", FO1, b_q);
		end_test("mail a to b");
		c_byte = 1'b1;
		op_c(1'b1, 18'h3a5c3);
		chk("mf2 after write", 36'h0, mf2);
		op_a(1'b0, 1'b1, 36'h0);
		chk("mf2 after read", 36'h1, mf2);
		chk("c_to_a_mail_register lanes", {18'h001c3, 18'h0}, a_q);
		chk("a_oe_n driving", 36'h0, a_oe_n);
		op_a(1'b0, 1'b0, 36'h0);
		chk("a queue data", {FO1, FO1}, a_q);
		c_byte = 1'b0;
		op_c(1'b0, 18'h00123);
		chk("fifo2 write pulse", 36'h1, wr2);
		end_test("mail c to a");
		for (int i = 1; i <= 1025; i++) begin
			op_a(1'b1, 1'b0, 36'(i));
			if (i == 8 || i == 9) begin
				// The first reader edge after the write may already have passed
				repeat (1 - (nbe - nb_wr)) @(posedge b_clk);
				edges(1, 0);
				chk("ae_b one edge", 36'h0, ae_b);
				edges(1, 1);
				chk("ae_b two edges", 36'(i == 9), ae_b);
			end
			if (i == 1015 || i == 1016) chk("af_a level", 36'(i == 1015), af_a);
			if (i >= 1023) chk("ff_a level", 36'(i == 1023), ff_a);
		end
		chk("refused write", 36'd1024, wr1);
		chk("ae_a fifo2", 36'h0, ae_a);
		@(negedge a_clk);
		@(posedge i_sys_clk);
		#1;
		mem1 = 1'b1;
		@(posedge i_sys_clk);
		#1;
		mem1 = 1'b0;
		edges(0, 1);
		chk("ff_a one edge", 36'h0, ff_a);
		edges(0, 1);
		chk("ff_a two edges", 36'h1, ff_a);
		chk("af_a still low", 36'h0, af_a);
		end_test("fill and drain");
		// Load offsets in order fifo1 empty, fifo1 full, fifo2 empty, fifo2 full
		a_prog = 1'b1;
		for (int k = 0; k < 4; k++) op_a(1'b1, 1'b0, (k == 2) ? 36'h0 : 36'h8);
		a_prog = 1'b0;
		edges(0, 2);
		chk("ae_a new offset", 36'h1, ae_a);
		chk("prog not queued", 36'd1024, wr1);
		end_test("offset program");
		give_verdict();
	end
endmodule : fflmb_top_tb
`default_nettype wire
